/* File: verilog/retimer_adapt_control_regs.v */
// Per-channel adaptation control and status register slice
`timescale 1ns/1ns
`include "retimer_adapt_control_regs.vh"

module retimer_adapt_control_regs
(
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Register port
   input wire [7:0] regAddr,
   input wire regWrite,
   input wire [7:0] regWrData,
   input wire regRead,
   output reg [7:0] regRdData,
   // Eye measurements
   input wire [7:0] horizontal_eye_opening,
   input wire [7:0] vertical_eye_opening,
   // Status from core
   input wire cdrInterrupt,
   input wire ppmCalcDone,
   input wire [7:0] linEqState,
   input wire [7:0] fbEqState,
   input wire cdrLockRaw,
   input wire frequency_lock_detector,
   input wire [1:0] internalDacRange,
   // Raw DFE tap magnitudes
   input wire [4:0] tap1Mag,
   input wire [15:0] tap25Mag,
   // Adaptation controls
   output reg [1:0] adaptMode,
   output reg useHorizontal,
   output reg useVertical,
   output reg eyeInterrupt,
   output reg horizBelowThr,
   output reg vertBelowThr,
   output reg handoffHoriz,
   output reg handoffVert,
   // PPM error calculation
   output reg ppmCalcStart,
   // Clamped taps
   output reg [4:0] tap1Clamped,
   output reg [15:0] tap25Clamped,
   // PRBS, lock and DAC
   output reg prbsClkEnable,
   output reg [1:0] prbsPattern,
   output reg lockDeclared,
   output reg [1:0] capDacRange
);

   localparam ST_IDLE = 1'b0;
   localparam ST_BUSY = 1'b1;

   reg [7:0] lockQual;
   reg [7:0] prbsCdr;
   reg [7:0] modeCtrl;
   reg [7:0] eyeThr;
   reg [7:0] handThr;
   reg [7:0] lockTap;
   reg [7:0] ppmTap1;
   reg [7:0] eyeEnDac;
   reg cdrIntPrev;
   reg ppmState;
   reg [7:0] next_rdData;
   integer i;

   function [4:0] clampMag;
      input [4:0] mag;
      input [4:0] limit;
      begin
         clampMag = (mag > limit) ? limit : mag;
      end
   endfunction

   function [3:0] clampNib;
      input [3:0] mag;
      input [3:0] limit;
      begin
         clampNib = (mag > limit) ? limit : mag;
      end
   endfunction

   function [7:0] scaleBy4;
      input [3:0] thr;
      begin
         scaleBy4 = {2'b00, thr, 2'b00};
      end
   endfunction

   function [7:0] scaleBy2;
      input [3:0] thr;
      begin
         scaleBy2 = {3'b000, thr, 1'b0};
      end
   endfunction

   wire wrLockQual = regWrite && (regAddr == `ADDR_LOCK_QUAL);
   wire wrPrbs = regWrite && (regAddr == `ADDR_PRBS_CDR);
   wire wrMode = regWrite && (regAddr == `ADDR_ADAPT_MODE);
   wire wrEyeThr = regWrite && (regAddr == `ADDR_EYE_INT_THR);
   wire wrHand = regWrite && (regAddr == `ADDR_HANDOFF_THR);
   wire wrLockTap = regWrite && (regAddr == `ADDR_LOCK_TAP);
   wire wrPpm = regWrite && (regAddr == `ADDR_PPM_TAP1);
   wire wrEyeEn = regWrite && (regAddr == `ADDR_EYE_EN_DAC);
   wire rdPrbs = regRead && (regAddr == `ADDR_PRBS_CDR);
   wire cdrRise = cdrInterrupt && !cdrIntPrev;
   wire ppmFinish = (ppmState == ST_BUSY) && ppmCalcDone;
   wire ppmNewReq = wrPpm && regWrData[`PPM_REQ_BIT];

   wire [1:0] meritSel = modeCtrl[`MERIT_HI:`MERIT_LO];
   wire selH = (meritSel != `MERIT_VERT);
   wire selV = (meritSel != `MERIT_HORIZ);
   wire hBelow = horizontal_eye_opening <
      scaleBy4(eyeThr[`THR_H_HI:`THR_H_LO]);
   wire vBelow = vertical_eye_opening <
      scaleBy4(eyeThr[`THR_V_HI:`THR_V_LO]);
   // Both hand-off checks use the horizontal opening
   wire hHandoff = horizontal_eye_opening >=
      scaleBy2(handThr[`THR_H_HI:`THR_H_LO]);
   wire vHandoff = horizontal_eye_opening >=
      scaleBy2(handThr[`THR_V_HI:`THR_V_LO]);

   // Plain read/write registers
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         lockQual <= `RST_LOCK_QUAL;
         modeCtrl <= `RST_ADAPT_MODE;
         eyeThr <= `RST_EYE_INT_THR;
         handThr <= `RST_HANDOFF_THR;
         eyeEnDac <= `RST_EYE_EN_DAC;
      end
      else
      begin
         if (wrLockQual)
            lockQual <= regWrData & `WMASK_LOCK_QUAL;
         if (wrMode)
            modeCtrl <= regWrData & `WMASK_ADAPT_MODE;
         if (wrEyeThr)
            eyeThr <= regWrData;
         if (wrHand)
            handThr <= regWrData;
         if (wrEyeEn)
            eyeEnDac <= regWrData;
      end
   end

   // CDR interrupt flag, set wins over clear on read
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prbsCdr <= `RST_PRBS_CDR;
         cdrIntPrev <= 1'b0;
      end
      else
      begin
         cdrIntPrev <= cdrInterrupt;
         if (wrPrbs)
            prbsCdr <= (prbsCdr & ~`WMASK_PRBS_CDR) |
               (regWrData & `WMASK_PRBS_CDR);
         if (cdrRise)
            prbsCdr[`CDR_INT_BIT] <= 1'b1;
         else if (rdPrbs)
            prbsCdr[`CDR_INT_BIT] <= 1'b0;
      end
   end

   // PPM request handshake and tap limits
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         lockTap <= `RST_LOCK_TAP;
         ppmTap1 <= `RST_PPM_TAP1;
         ppmState <= ST_IDLE;
         ppmCalcStart <= 1'b0;
      end
      else
      begin
         ppmCalcStart <= 1'b0;
         if (wrLockTap)
            lockTap <= (lockTap & ~`WMASK_LOCK_TAP) |
               (regWrData & `WMASK_LOCK_TAP);
         if (wrPpm)
            ppmTap1 <= regWrData & `WMASK_PPM_TAP1;
         case (ppmState)
            ST_IDLE:
            begin
               if (ppmNewReq)
               begin
                  ppmState <= ST_BUSY;
                  ppmCalcStart <= 1'b1;
               end
            end
            ST_BUSY:
            begin
               if (ppmCalcDone)
               begin
                  ppmState <= ST_IDLE;
                  ppmTap1[`PPM_REQ_BIT] <= 1'b0;
               end
            end
            default:
               ppmState <= ST_IDLE;
         endcase
         if (ppmFinish)
            lockTap[`PPM_READY_BIT] <= 1'b1;
         else if (ppmNewReq)
            lockTap[`PPM_READY_BIT] <= 1'b0;
      end
   end

   // Mode, merit and eye comparison outputs
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         adaptMode <= 2'h0;
         useHorizontal <= 1'b0;
         useVertical <= 1'b0;
         eyeInterrupt <= 1'b0;
         horizBelowThr <= 1'b0;
         vertBelowThr <= 1'b0;
         handoffHoriz <= 1'b0;
         handoffVert <= 1'b0;
      end
      else
      begin
         adaptMode <= modeCtrl[`MODE_HI:`MODE_LO];
         useHorizontal <= selH;
         useVertical <= selV;
         horizBelowThr <= hBelow;
         vertBelowThr <= vBelow;
         eyeInterrupt <= eyeEnDac[`EYE_INT_EN_BIT] &&
            ((selH && hBelow) || (selV && vBelow));
         handoffHoriz <= hHandoff;
         handoffVert <= vHandoff;
      end
   end

   // Clamped DFE tap magnitudes
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         tap1Clamped <= 5'h00;
         tap25Clamped <= 16'h0000;
      end
      else
      begin
         tap1Clamped <= clampMag(tap1Mag,
            ppmTap1[`TAP1_HI:`TAP1_LO]);
         for (i = 0; i < `TAP25_NUM; i = i + 1)
            tap25Clamped[i*`TAP25_W +: `TAP25_W] <=
               clampNib(tap25Mag[i*`TAP25_W +: `TAP25_W],
               lockTap[`TAP25_HI:`TAP25_LO]);
      end
   end

   // PRBS, lock qualifier and DAC range outputs
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prbsClkEnable <= 1'b0;
         prbsPattern <= 2'h0;
         lockDeclared <= 1'b0;
         capDacRange <= 2'h0;
      end
      else
      begin
         prbsClkEnable <= prbsCdr[`PRBS_CLK_BIT];
         prbsPattern <= prbsCdr[`PRBS_PAT_HI:`PRBS_PAT_LO];
         lockDeclared <= cdrLockRaw && (!lockQual[`FLD_EN_BIT] ||
            frequency_lock_detector);
         capDacRange <= eyeEnDac[`DAC_OVR_BIT] ?
            eyeEnDac[`DAC_RANGE_HI:`DAC_RANGE_LO] :
            internalDacRange;
      end
   end

   // Read mux
   always @*
   begin
      next_rdData = `ZERO8;
      case (regAddr)
         `ADDR_LOCK_QUAL: next_rdData = lockQual;
         `ADDR_PRBS_CDR: next_rdData = prbsCdr;
         `ADDR_ADAPT_MODE: next_rdData = modeCtrl;
         `ADDR_EYE_INT_THR: next_rdData = eyeThr;
         `ADDR_HANDOFF_THR: next_rdData = handThr;
         `ADDR_LOCK_TAP: next_rdData = lockTap;
         `ADDR_PPM_TAP1: next_rdData = ppmTap1;
         `ADDR_EYE_EN_DAC: next_rdData = eyeEnDac;
         `ADDR_LIN_STATE: next_rdData = linEqState;
         `ADDR_FB_STATE: next_rdData = fbEqState;
         default: next_rdData = `ZERO8;
      endcase
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         regRdData <= `ZERO8;
      else if (regRead)
         regRdData <= next_rdData;
   end

endmodule

/* File: common/retimer_adapt_control_regs.vh */
// Register offsets, field positions and reset values of the adapt slice
`ifndef RETIMER_ADAPT_CONTROL_REGS_VH
`define RETIMER_ADAPT_CONTROL_REGS_VH

`define ADDR_LOCK_QUAL 8'h2F
`define ADDR_PRBS_CDR 8'h30
`define ADDR_ADAPT_MODE 8'h31
`define ADDR_EYE_INT_THR 8'h32
`define ADDR_HANDOFF_THR 8'h33
`define ADDR_LOCK_TAP 8'h34
`define ADDR_PPM_TAP1 8'h35
`define ADDR_EYE_EN_DAC 8'h36
`define ADDR_LIN_STATE 8'h37
`define ADDR_FB_STATE 8'h38

`define RST_LOCK_QUAL 8'h02
`define RST_PRBS_CDR 8'h00
`define RST_ADAPT_MODE 8'h40
`define RST_EYE_INT_THR 8'h11
`define RST_HANDOFF_THR 8'h88
`define RST_LOCK_TAP 8'h3F
`define RST_PPM_TAP1 8'h1F
`define RST_EYE_EN_DAC 8'h31

// Writable bits of the masked registers; eyeThr, handThr and eyeEnDac take all bits
`define WMASK_LOCK_QUAL 8'h02
`define WMASK_PRBS_CDR 8'hCF
`define WMASK_ADAPT_MODE 8'h78
`define WMASK_LOCK_TAP 8'h7F
`define WMASK_PPM_TAP1 8'hFF

`define FLD_EN_BIT 1
`define CDR_INT_BIT 4
`define PRBS_CLK_BIT 3
`define PRBS_PAT_HI 1
`define PRBS_PAT_LO 0
`define MODE_HI 6
`define MODE_LO 5
`define MERIT_HI 4
`define MERIT_LO 3
`define THR_H_HI 7
`define THR_H_LO 4
`define THR_V_HI 3
`define THR_V_LO 0
`define PPM_READY_BIT 7
`define TAP25_HI 3
`define TAP25_LO 0
`define TAP25_NUM 4
`define TAP25_W 4
`define PPM_REQ_BIT 5
`define TAP1_HI 4
`define TAP1_LO 0
`define EYE_INT_EN_BIT 6
`define DAC_OVR_BIT 2
`define DAC_RANGE_HI 1
`define DAC_RANGE_LO 0

`define MERIT_BOTH0 2'h0
`define MERIT_HORIZ 2'h1
`define MERIT_VERT 2'h2

`define ZERO8 8'h00

`endif

/* File: bench/retimer_adapt_checker.sv */
// Concurrent checks on the adaptation control register slice ports
`timescale 1ns/1ns
module retimer_adapt_checker
(
   // Clock, reset and register port
   input wire clk_sys,
   input wire resetn,
   input wire [7:0] regAddr,
   input wire regWrite,
   input wire [7:0] regWrData,
   input wire regRead,
   input wire [7:0] regRdData,
   // Core inputs
   input wire [7:0] horizontal_eye_opening,
   input wire cdrInterrupt,
   input wire ppmCalcDone,
   input wire [4:0] tap1Mag,
   // Derived outputs
   input wire [1:0] adaptMode,
   input wire useHorizontal,
   input wire useVertical,
   input wire eyeInterrupt,
   input wire horizBelowThr,
   input wire vertBelowThr,
   input wire handoffHoriz,
   input wire handoffVert,
   input wire ppmCalcStart,
   input wire [4:0] tap1Clamped,
   input wire prbsClkEnable,
   input wire [1:0] prbsPattern
);
   reg pend;
   wire reqNow = regWrite && regAddr == 8'h35 && regWrData[5];
   // Tracks an accepted PPM request until done
   always @(posedge clk_sys or negedge resetn)
      if (!resetn)
         pend <= 1'b0;
      else if (reqNow)
         pend <= 1'b1;
      else if (ppmCalcDone)
         pend <= 1'b0;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_rise;
      !cdrInterrupt ##1 cdrInterrupt;
   endsequence
   sequence s_rd30;
      regRead && regAddr == 8'h30;
   endsequence
   a_mode_write: assert property (
      regWrite && regAddr == 8'h31 |->
      ##2 adaptMode == $past(regWrData[6:5], 2))
      else $error("adaptMode wrong after write");
   a_prbs_write: assert property (
      regWrite && regAddr == 8'h30 |-> ##2
      {prbsClkEnable, prbsPattern} == $past({regWrData[3], regWrData[1:0]}, 2))
      else $error("prbs controls wrong after write");
   a_eye_gate: assert property (
      eyeInterrupt |->
      (useHorizontal && horizBelowThr) || (useVertical && vertBelowThr))
      else $error("eye condition without cause");
   a_heo_full: assert property (
      $past(horizontal_eye_opening) == 8'hff |->
      handoffHoriz && handoffVert && !horizBelowThr)
      else $error("full opening misjudged");
   a_tap1_clamp: assert property (
      tap1Clamped <= $past(tap1Mag)) else $error("tap1 above raw value");
   a_ppm_pulse: assert property (
      ppmCalcStart |=> !ppmCalcStart) else $error("ppm start too long");
   a_ppm_start: assert property (
      ppmCalcStart == $past(reqNow && !pend)) else $error("ppm start wrong");
   a_cdr_flag: assert property (
      s_rise ##1 s_rd30 |=> regRdData[4]) else $error("cdr flag missing");
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the adaptation control register slice
`timescale 1ns/1ns
module tb_top;
   reg clk_sys = 0, resetn = 0, regWrite = 0, regRead = 0;
   reg cdrInterrupt = 0, ppmCalcDone = 0, cdrLockRaw = 0;
   reg frequency_lock_detector = 0;
   reg [7:0] regAddr = 0, regWrData = 0, horizontal_eye_opening = 0;
   reg [7:0] vertical_eye_opening = 0, linEqState = 8'ha5, fbEqState = 8'h3c;
   reg [1:0] internalDacRange = 0;
   reg [4:0] tap1Mag = 0;
   reg [15:0] tap25Mag = 0;
   wire [7:0] regRdData;
   wire [1:0] adaptMode, prbsPattern, capDacRange;
   wire useHorizontal, useVertical, eyeInterrupt, horizBelowThr, vertBelowThr;
   wire handoffHoriz, handoffVert, ppmCalcStart, prbsClkEnable, lockDeclared;
   wire [4:0] tap1Clamped;
   wire [15:0] tap25Clamped;
   integer err_total = 0, tests_run = 0, cyc = 0, i;
   localparam [79:0] RST = 80'h0200_4011_883f_1f31_a53c;
   retimer_adapt_control_regs u_retimer_adapt_control_regs (
      .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
      .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
      .regRdData(regRdData),
      .horizontal_eye_opening(horizontal_eye_opening),
      .vertical_eye_opening(vertical_eye_opening),
      .cdrInterrupt(cdrInterrupt), .ppmCalcDone(ppmCalcDone),
      .linEqState(linEqState), .fbEqState(fbEqState),
      .cdrLockRaw(cdrLockRaw),
      .frequency_lock_detector(frequency_lock_detector),
      .internalDacRange(internalDacRange), .tap1Mag(tap1Mag),
      .tap25Mag(tap25Mag), .adaptMode(adaptMode),
      .useHorizontal(useHorizontal), .useVertical(useVertical),
      .eyeInterrupt(eyeInterrupt), .horizBelowThr(horizBelowThr),
      .vertBelowThr(vertBelowThr), .handoffHoriz(handoffHoriz),
      .handoffVert(handoffVert), .ppmCalcStart(ppmCalcStart),
      .tap1Clamped(tap1Clamped), .tap25Clamped(tap25Clamped),
      .prbsClkEnable(prbsClkEnable), .prbsPattern(prbsPattern),
      .lockDeclared(lockDeclared), .capDacRange(capDacRange)
   );
   initial
      forever #25 clk_sys = ~clk_sys;
   task chk(input [15:0] s, input [15:0] e, input [8*8-1:0] n);
      begin
         tests_run = tests_run + 1;
         if (s !== e)
         begin
            err_total = err_total + 1;
            $display("Error %0s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task step;
      begin
         @(posedge clk_sys);
         #5;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         step;
         regWrite = 1;
         regAddr = a;
         regWrData = d;
         step;
         regWrite = 0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         step;
         regRead = 1;
         regAddr = a;
         step;
         regRead = 0;
         chk(regRdData, e, "readback");
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task t_regs;
      begin
         for (i = 0; i < 10; i = i + 1)
            rd(8'h2f + i[7:0], RST[79-8*i -:8]);
         rd(8'h50, 8'h00);
         for (i = 0; i < 4; i = i + 1)
         begin
            wr(8'h31, {1'b1, i[1:0], i[1:0], 3'h7});
            step;
            chk(adaptMode, i[1:0], "mode");
            chk({useHorizontal, useVertical}, {i!=2, i!=1}, "merit");
            rd(8'h31, {1'b0, i[1:0], i[1:0], 3'h0});
         end
         $display("register and mode test done");
      end
   endtask
   task t_eye;
      begin
         wr(8'h32, 8'h23);
         wr(8'h33, 8'h45);
         wr(8'h36, 8'h40);
         internalDacRange = 2'h2;
         horizontal_eye_opening = 8'h07;
         vertical_eye_opening = 8'h0c;
         step;
         chk({horizBelowThr, vertBelowThr, eyeInterrupt, handoffHoriz,
            handoffVert}, 5'h14, "eye");
         chk(capDacRange, 2'h2, "dac");
         horizontal_eye_opening = 8'h0a;
         vertical_eye_opening = 8'h0b;
         step;
         chk({horizBelowThr, vertBelowThr, eyeInterrupt, handoffHoriz,
            handoffVert}, 5'h0f, "eye");
         horizontal_eye_opening = 8'hff;
         step;
         chk({horizBelowThr, handoffHoriz, handoffVert}, 3'h3,
            "eyefull");
         wr(8'h36, 8'h07);
         step;
         chk({eyeInterrupt, capDacRange}, 3'h3, "eyedac");
         $display("eye test done");
      end
   endtask
   task t_tap_ppm;
      begin
         wr(8'h34, 8'h05);
         wr(8'h35, 8'h09);
         tap1Mag = 5'h1f;
         tap25Mag = 16'h0f36;
         step;
         chk(tap1Clamped, 5'h09, "tap1");
         chk(tap25Clamped, 16'h0535, "tap25");
         wr(8'h35, 8'h29);
         chk(ppmCalcStart, 1'b1, "ppmstart");
         wr(8'h35, 8'h29);
         chk(ppmCalcStart, 1'b0, "ppmstart");
         rd(8'h34, 8'h05);
         ppmCalcDone = 1;
         step;
         ppmCalcDone = 0;
         rd(8'h35, 8'h09);
         rd(8'h34, 8'h85);
         $display("tap and ppm test done");
      end
   endtask
   task t_misc;
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            wr(8'h30, {4'hf, i[0], 1'b1, i[1:0]});
            step;
            chk({prbsClkEnable, prbsPattern}, {i[0], i[1:0]}, "prbs");
            rd(8'h30, {4'hc, i[0], 1'b1, i[1:0]});
         end
         cdrInterrupt = 1;
         rd(8'h30, 8'hdf);
         cdrInterrupt = 0;
         rd(8'h30, 8'hcf);
         cdrLockRaw = 1;
         step;
         chk(lockDeclared, 1'b0, "lock");
         frequency_lock_detector = 1;
         step;
         chk(lockDeclared, 1'b1, "lock");
         frequency_lock_detector = 0;
         wr(8'h2f, 8'h00);
         step;
         chk(lockDeclared, 1'b1, "lock");
         $display("prbs cdr lock test done");
      end
   endtask
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         err_total = err_total + 1;
         complete_run;
      end
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      #5 resetn = 1;
      t_regs;
      t_eye;
      t_tap_ppm;
      t_misc;
      complete_run;
   end
endmodule
bind retimer_adapt_control_regs retimer_adapt_checker u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
   .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
   .regRdData(regRdData), .horizontal_eye_opening(horizontal_eye_opening),
   .cdrInterrupt(cdrInterrupt), .ppmCalcDone(ppmCalcDone),
   .tap1Mag(tap1Mag), .adaptMode(adaptMode),
   .useHorizontal(useHorizontal), .useVertical(useVertical),
   .eyeInterrupt(eyeInterrupt), .horizBelowThr(horizBelowThr),
   .vertBelowThr(vertBelowThr), .handoffHoriz(handoffHoriz),
   .handoffVert(handoffVert), .ppmCalcStart(ppmCalcStart),
   .tap1Clamped(tap1Clamped), .prbsClkEnable(prbsClkEnable),
   .prbsPattern(prbsPattern)
);
